// file: inc/nms_pkg.sv
package nms_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] QUIET_OFS = 8'h08;

  // control register fields
  localparam int CTRL_INIT_REQ_BIT = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_CARD_BIT = 2;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int CTRL_XHS_BIT = 7;
  localparam int CTRL_TXN_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // status register fields
  localparam int STAT_ROLE_BIT = 0;
  localparam int STAT_FIELD_BIT = 1;
  localparam int STAT_DET_BIT = 2;
  localparam int STAT_EXT_BIT = 3;
  localparam int STAT_FRAMF_BIT = 4;
  localparam int STAT_SPEED_LSB = 5;
  localparam int STAT_SPERR_BIT = 7;
  localparam int STAT_STATE_LSB = 8;

  // speed codes; 3 is above 424 kbit/s and needs external circuitry
  localparam logic [1:0] SPD_106 = 2'h0;
  localparam logic [1:0] SPD_212 = 2'h1;
  localparam logic [1:0] SPD_424 = 2'h2;
  localparam logic [1:0] SPD_HIGH = 2'h3;

  // reply coding selections
  localparam logic [1:0] CODE_MANCH_SUB = 2'h0;
  localparam logic [1:0] CODE_BPSK_SUB = 2'h1;
  localparam logic [1:0] CODE_MANCH_DIRECT = 2'h2;

  // miller bit periods in carrier cycles
  localparam logic [7:0] MILLER_106_CYC = 8'h80;
  localparam logic [7:0] MILLER_212_CYC = 8'h40;
  localparam logic [7:0] MILLER_424_CYC = 8'h20;
  localparam logic [4:0] SUBCARRIER_DIV = 5'h10;

  // initial field quiet time
  localparam int CLK_HZ = 25000000;
  localparam int QUIET_TIME_US = 5000;
  localparam int QUIET_CYC = (QUIET_TIME_US * (CLK_HZ / 1000000));
  localparam logic [31:0] QUIET_RESET = 32'h0001e848;

  typedef enum logic [1:0] {
    ST_TARGET = 2'b00,
    ST_WAIT_QUIET = 2'b01,
    ST_INITIATOR = 2'b10
  } nms_state_t;

endpackage : nms_pkg

// file: rtl/nms_mode_select.sv
`timescale 1ns/10ps
// What this block does
// - active and passive peer-to-peer at 106, 212 and 424 kbit/s
// - whichever side transmits in active mode makes its own field
// - passive target only load-modulates, never makes a field
// - initiator makes the 13.56 MHz carrier and opens exchanges
// - speeds above 424 kbit/s only with external circuitry present
// - 106 kbit/s uses Type A framing, active and passive
// - 212 and 424 kbit/s use Type F framing; Manchester bits in card mode, BPSK otherwise
// - after reset: target role, own field off
// - idle target keeps the level detector enabled
// - initiator field on only after a full quiet interval, unless active mode lights it while waiting
// - Type A emulation: subcarrier fc/16, Manchester, at 106 only
// - Type F emulation: direct Manchester load modulation, 212/424
module nms_mode_select #(
  parameter logic [31:0] QUIET_CYCLES = nms_pkg::QUIET_RESET
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // analogue front end
  input wire logic EXT_FIELD,
  input wire logic EXT_HS_PRESENT,
  output logic FIELD_ON,
  output logic LEVEL_DET_EN,
  output logic LOAD_MOD_EN,
  output logic INITIATOR,
  // coding selection
  output logic FRAME_TYPE_F,
  output logic [1:0] SPEED,
  output logic [1:0] REPLY_CODING,
  output logic [7:0] MILLER_PERIOD
);

  function automatic logic [7:0] miller_cycles(input logic [1:0] spd);
    unique case (spd)
      nms_pkg::SPD_106: miller_cycles = nms_pkg::MILLER_106_CYC;
      nms_pkg::SPD_212: miller_cycles = nms_pkg::MILLER_212_CYC;
      default: miller_cycles = nms_pkg::MILLER_424_CYC;
    endcase
  endfunction : miller_cycles

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ext_m_q, ext_s_q, xhs_m_q, xhs_s_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
      xhs_m_q <= 1'b0;
      xhs_s_q <= 1'b0;
    end else begin
      ext_m_q <= EXT_FIELD;
      ext_s_q <= ext_m_q;
      xhs_m_q <= EXT_HS_PRESENT;
      xhs_s_q <= xhs_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [8:0] ctrl_q;
  logic [31:0] quiet_q;
  logic speed_err_q;
  nms_pkg::nms_state_t state_q, state_d;

  wire wr_en = PSEL && PENABLE && PWRITE;
  wire hit_ctrl = (PADDR == nms_pkg::CTRL_OFS);
  wire hit_stat = (PADDR == nms_pkg::STAT_OFS);
  wire hit_quiet = (PADDR == nms_pkg::QUIET_OFS);
  wire unmapped = !(hit_ctrl || hit_stat || hit_quiet);

  wire [1:0] wr_speed = PWDATA[nms_pkg::CTRL_SPEED_LSB +: 2];
  wire [1:0] cur_speed = ctrl_q[nms_pkg::CTRL_SPEED_LSB +: 2];
  wire txn_open = ctrl_q[nms_pkg::CTRL_TXN_BIT];
  // high speed refused unless external circuitry is strapped present
  wire speed_bad = (wr_speed == nms_pkg::SPD_HIGH) && !xhs_s_q;
  // speed change inside an open transaction is refused, protects the link
  wire speed_lock = txn_open && (wr_speed != cur_speed);
  wire speed_keep = speed_bad || speed_lock;
  // bits 6 and 3 are unused and read back as zero
  wire [8:0] ctrl_wr = {PWDATA[nms_pkg::CTRL_TXN_BIT], PWDATA[nms_pkg::CTRL_XHS_BIT],
                        1'b0, speed_keep ? cur_speed : wr_speed, 1'b0,
                        PWDATA[nms_pkg::CTRL_CARD_BIT:0]};
  wire [8:0] ctrl_d = (wr_en && hit_ctrl) ? ctrl_wr : ctrl_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctrl_q <= nms_pkg::CTRL_RESET;
      quiet_q <= QUIET_CYCLES;
      speed_err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_en && hit_quiet) begin
        quiet_q <= PWDATA;
      end
      // set wins over the read-clear
      if (wr_en && hit_ctrl && speed_keep) begin
        speed_err_q <= 1'b1;
      end else if (PSEL && PENABLE && !PWRITE && hit_stat) begin
        speed_err_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // role state machine
  wire init_req = ctrl_q[nms_pkg::CTRL_INIT_REQ_BIT];
  wire active_mode = ctrl_q[nms_pkg::CTRL_ACTIVE_BIT];
  wire card_mode = ctrl_q[nms_pkg::CTRL_CARD_BIT];
  wire quiet_done;

  nms_quiet_timer #(
    .WIDTH(32)
  ) u_quiet (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .run(state_q == nms_pkg::ST_WAIT_QUIET),
    .field_seen(ext_s_q),
    .limit(quiet_q),
    .expired(quiet_done)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      nms_pkg::ST_TARGET: begin
        if (init_req && !card_mode) begin
          state_d = nms_pkg::ST_WAIT_QUIET;
        end
      end
      nms_pkg::ST_WAIT_QUIET: begin
        if (!init_req || card_mode) begin
          state_d = nms_pkg::ST_TARGET;
        end else if (quiet_done) begin
          state_d = nms_pkg::ST_INITIATOR;
        end
      end
      nms_pkg::ST_INITIATOR: begin
        if (!init_req || card_mode) begin
          state_d = nms_pkg::ST_TARGET;
        end
      end
      default: state_d = nms_pkg::ST_TARGET;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_q <= nms_pkg::ST_TARGET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire is_init_d = (state_d == nms_pkg::ST_INITIATOR);
  // initiator owns the carrier; an active-mode target makes its own field
  wire field_d = is_init_d || (active_mode && !card_mode && !ext_s_q);
  wire passive_target_d = !is_init_d && (!active_mode || card_mode);
  wire det_d = !field_d || (state_d != nms_pkg::ST_INITIATOR);
  wire type_f_d = (cur_speed != nms_pkg::SPD_106);
  logic [1:0] coding_d;
  // reply coding per emulation type and speed
  assign coding_d = (type_f_d && card_mode) ? nms_pkg::CODE_MANCH_DIRECT :
                    (cur_speed == nms_pkg::SPD_106) ? nms_pkg::CODE_MANCH_SUB :
                    nms_pkg::CODE_BPSK_SUB;
  wire [31:0] status = {22'h0, state_q, speed_err_q, cur_speed, FRAME_TYPE_F,
                        ext_s_q, LEVEL_DET_EN, FIELD_ON, INITIATOR};
  wire [31:0] rdata_d = hit_ctrl ? {23'h0, ctrl_q} : hit_stat ? status :
                        hit_quiet ? quiet_q : 32'h0;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      FIELD_ON <= 1'b0;
      LEVEL_DET_EN <= 1'b1;
      LOAD_MOD_EN <= 1'b1;
      INITIATOR <= 1'b0;
      FRAME_TYPE_F <= 1'b0;
      SPEED <= nms_pkg::SPD_106;
      REPLY_CODING <= nms_pkg::CODE_MANCH_SUB;
      MILLER_PERIOD <= nms_pkg::MILLER_106_CYC;
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      FIELD_ON <= field_d;
      LEVEL_DET_EN <= det_d;
      LOAD_MOD_EN <= passive_target_d;
      INITIATOR <= is_init_d;
      FRAME_TYPE_F <= type_f_d;
      SPEED <= cur_speed;
      REPLY_CODING <= coding_d;
      MILLER_PERIOD <= miller_cycles(cur_speed);
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && unmapped;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rdata_d : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_reset_role;
    @(posedge SYS_CLK) !RSTN |=> (!FIELD_ON && !INITIATOR);
  endproperty
  a_reset_role: assert property (p_reset_role) else $error("not target after reset");

  property p_field_quiet;
    @(posedge SYS_CLK) disable iff (!RSTN)
      $rose(INITIATOR) |-> $past(state_q) == nms_pkg::ST_WAIT_QUIET && !$past(ext_s_q);
  endproperty
  a_field_quiet: assert property (p_field_quiet) else $error("field on without quiet");

  property p_passive_nofield;
    @(posedge SYS_CLK) disable iff (!RSTN) LOAD_MOD_EN |-> !INITIATOR;
  endproperty
  a_passive_nofield: assert property (p_passive_nofield) else $error("passive initiator");

  property p_init_field;
    @(posedge SYS_CLK) disable iff (!RSTN) INITIATOR |-> FIELD_ON;
  endproperty
  a_init_field: assert property (p_init_field) else $error("initiator without field");

  property p_high_speed;
    @(posedge SYS_CLK) disable iff (!RSTN) (SPEED == nms_pkg::SPD_HIGH) |-> $past(xhs_s_q, 2);
  endproperty
  a_high_speed: assert property (p_high_speed) else $error("high speed without circuit");

  property p_framing;
    @(posedge SYS_CLK) disable iff (!RSTN) FRAME_TYPE_F == (SPEED != nms_pkg::SPD_106);
  endproperty
  a_framing: assert property (p_framing) else $error("framing mismatch");

  property p_detector;
    @(posedge SYS_CLK) disable iff (!RSTN) !INITIATOR |-> LEVEL_DET_EN;
  endproperty
  a_detector: assert property (p_detector) else $error("detector off as target");

  property p_miller;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (SPEED == nms_pkg::SPD_212) |-> MILLER_PERIOD == nms_pkg::MILLER_212_CYC;
  endproperty
  a_miller: assert property (p_miller) else $error("miller period wrong");

  property p_speed_lock;
    @(posedge SYS_CLK) disable iff (!RSTN) txn_open && $past(txn_open) |-> $stable(cur_speed);
  endproperty
  a_speed_lock: assert property (p_speed_lock) else $error("speed changed in transaction");

  // a load-modulating target must never light its own field
  property p_passive_dark;
    @(posedge SYS_CLK) disable iff (!RSTN)
      LOAD_MOD_EN |-> !FIELD_ON;
  endproperty
  a_passive_dark: assert property (p_passive_dark) else $error("passive target with field");

  property p_reset_det;
    @(posedge SYS_CLK)
      !RSTN |=> (LEVEL_DET_EN && LOAD_MOD_EN);
  endproperty
  a_reset_det: assert property (p_reset_det) else $error("detector off after reset");

  // the detector must watch for the whole quiet interval
  property p_wait_det;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (state_q == nms_pkg::ST_WAIT_QUIET) |-> LEVEL_DET_EN;
  endproperty
  a_wait_det: assert property (p_wait_det) else $error("detector off while waiting");

  property p_card_target;
    @(posedge SYS_CLK) disable iff (!RSTN)
      $past(card_mode) |-> !INITIATOR;
  endproperty
  a_card_target: assert property (p_card_target) else $error("initiator in card mode");

  property p_coding_a;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (SPEED == nms_pkg::SPD_106) |-> REPLY_CODING == nms_pkg::CODE_MANCH_SUB;
  endproperty
  a_coding_a: assert property (p_coding_a) else $error("coding wrong at 106");

  property p_coding_f;
    @(posedge SYS_CLK) disable iff (!RSTN)
      $past(card_mode) && FRAME_TYPE_F |-> REPLY_CODING == nms_pkg::CODE_MANCH_DIRECT;
  endproperty
  a_coding_f: assert property (p_coding_f) else $error("card coding wrong above 106");

  property p_miller_106;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (SPEED == nms_pkg::SPD_106) |-> MILLER_PERIOD == nms_pkg::MILLER_106_CYC;
  endproperty
  a_miller_106: assert property (p_miller_106) else $error("miller period wrong at 106");

  property p_miller_424;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (SPEED == nms_pkg::SPD_424) |-> MILLER_PERIOD == nms_pkg::MILLER_424_CYC;
  endproperty
  a_miller_424: assert property (p_miller_424) else $error("miller period wrong at 424");

endmodule : nms_mode_select

// file: rtl/nms_quiet_timer.sv
`timescale 1ns/10ps
// counts consecutive cycles with no external field; any field restarts it
module nms_quiet_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic field_seen,
  input wire logic [WIDTH-1:0] limit,
  // result
  output logic expired
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire restart = !run || field_seen;
  wire at_limit = (cnt_q >= limit);

  assign cnt_d = restart ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
  assign expired = run && !field_seen && at_limit;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : nms_quiet_timer

// file: sim/nms_mode_select_test.sv
`timescale 1ns/10ps
module nms_mode_select_test;
  // short quiet interval keeps the run brief
  localparam logic [31:0] QC = 32'h10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ext, field_on, det_en, lm_en, init, type_f;
  logic hs = 1'b0;
  logic want = 1'b0;
  logic [1:0] speed, coding;
  logic [7:0] miller;
  int mismatches = 0;
  int num_checks = 0;
  int n;

  always #20 sys_clk = ~sys_clk;

  nms_mode_select #(.QUIET_CYCLES(QC)) dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_FIELD(ext), .EXT_HS_PRESENT(hs), .FIELD_ON(field_on), .LEVEL_DET_EN(det_en),
    .LOAD_MOD_EN(lm_en), .INITIATOR(init), .FRAME_TYPE_F(type_f), .SPEED(speed),
    .REPLY_CODING(coding), .MILLER_PERIOD(miller));

  nms_rf_peer peer (.clk(sys_clk), .want_field(want), .ext_field(ext));

  ////////////////////////////////////////////////////////////
  task cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : cyc

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // apb transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    mismatches++;
    give_verdict();
  end

  initial begin
    cyc(16);
    rstn <= 1'b1;
    cyc(2);
    check("field", field_on, 0);
    check("role", init, 0);
    check("det", det_en, 1);
    check("miller", miller, 8'h80);
    apb(1'b0, nms_pkg::CTRL_OFS, 0);
    check("ctrl", rd, 0);
    apb(1'b0, nms_pkg::QUIET_OFS, 0);
    check("quiet", rd, QC);
    apb(1'b0, 8'h0c, 0);
    check("unmapped", {rd[30:0], err}, 1);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, nms_pkg::CTRL_OFS, (s << 4) | 4);
      cyc(3);
      check("speed", speed, s);
      check("typef", type_f, s != 0);
      check("miller", miller, 8'h80 >> s);
      check("code", coding, (s == 0) ? nms_pkg::CODE_MANCH_SUB : nms_pkg::CODE_MANCH_DIRECT);
      check("lm", lm_en, 1);
    end
    // no high-speed circuitry yet: top speed is refused
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h34);
    cyc(3);
    check("speed", speed, 2);
    apb(1'b0, nms_pkg::STAT_OFS, 0);
    check("refused", rd[nms_pkg::STAT_SPERR_BIT], 1);
    hs <= 1'b1;
    cyc(4);
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h34);
    cyc(3);
    check("speed", speed, 3);
    check("typef", type_f, 1);
    check("miller", miller, 8'h20);
    // open transaction locks the speed
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h130);
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h100);
    cyc(3);
    check("locked", speed, 3);
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h030);
    apb(1'b1, nms_pkg::CTRL_OFS, 0);
    cyc(3);
    check("speed", speed, 0);
    want <= 1'b1;
    cyc(3);
    apb(1'b1, nms_pkg::CTRL_OFS, 1);
    cyc(40);
    check("held", field_on, 0);
    check("det", det_en, 1);
    apb(1'b0, nms_pkg::STAT_OFS, 0);
    check("wait", rd[9:8], 1);
    // a short burst of field must restart the quiet count
    want <= 1'b0;
    cyc(10);
    want <= 1'b1;
    cyc(2);
    want <= 1'b0;
    n = 0;
    while (field_on !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("quiet", n >= 16 && n < 40, 1);
    check("role", init, 1);
    apb(1'b1, nms_pkg::CTRL_OFS, 2);
    cyc(4);
    check("role", init, 0);
    check("active", field_on, 1);
    want <= 1'b1;
    cyc(6);
    check("active", field_on, 0);
    apb(1'b1, nms_pkg::CTRL_OFS, 0);
    want <= 1'b0;
    cyc(6);
    check("passive", field_on, 0);
    check("lm", lm_en, 1);
    // a reset in mid-run from active mode at 424 must fall back to idle target
    apb(1'b1, nms_pkg::CTRL_OFS, 32'h22);
    cyc(3);
    check("active", field_on, 1);
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(2);
    check("field", field_on, 0);
    check("role", init, 0);
    check("speed", speed, 0);
    check("det", det_en, 1);
    give_verdict();
  end
endmodule : nms_mode_select_test

// file: sim/nms_rf_peer.sv
`timescale 1ns/10ps
// remote party: raises or drops its own carrier one cycle after being asked
module nms_rf_peer (
  // clock
  input wire logic clk,
  // field control
  input wire logic want_field,
  output logic ext_field
);
  initial ext_field = 1'b0;
  // the far side makes its own field when it transmits
  always @(posedge clk) begin
    ext_field <= want_field;
  end
endmodule : nms_rf_peer
